/* logic/acf_consts.vh */
`ifndef ACF_CONSTS_VH
`define ACF_CONSTS_VH
// register offsets
`define ACF_OFS_STATUS      8'h02
`define ACF_OFS_CLKDIV      8'h03
`define ACF_OFS_FORMAT      8'h04
`define ACF_OFS_IRQ_STATUS  8'h10
`define ACF_OFS_IRQ_ENABLE  8'h11
`define ACF_OFS_IRQ_CLEAR   8'h12
`define ACF_OFS_CONTROL     8'h13
// converter_status fields
`define ACF_STS_CMD_SEL     7
`define ACF_STS_RES_SEL     6
`define ACF_STS_ECC_ERR     5
`define ACF_STS_READY       3
// result_format_control fields
`define ACF_FMT_JUST        7
`define ACF_FMT_RES_HI      2
// control fields (own register)
`define ACF_CTL_CMD_ERR     0
// resolution codes
`define ACF_RES_8BIT        3'h0
`define ACF_RES_10BIT       3'h2
`define ACF_RES_12BIT       3'h4
// interrupt status bits
`define ACF_IRQ_ECC         0
`define ACF_IRQ_CMD_ERR     1
`define ACF_IRQ_READY       2
// reset values
`define ACF_RST_PRESCALER   7'h00
`define ACF_RST_FORMAT_RES  3'h0
`endif

/* logic/acf_regs.v */
// Notes on behaviour
// - double ecc error sets flag and halts conversions until soft reset
// - soft reset clears command and result list select bits
// - list select writes accepted only when disabled or special access set
// - ecc error flag and ready flag are read only
// - double mode: command select toggles when idle, load ok and restart
// - single buffer command mode holds command select at zero
// - double buffer results: toggle on first result stored or list abort
// - single buffer result mode holds result select at zero
// - select value 0 picks list 0, value 1 picks list 1
// - ecc error flag cleared whenever converter is disabled
// - ready reads one when idle and restart needs no latency
// - conversion clock is bus clock over two times (prescaler plus one)
// - prescaler writable only when disabled or special access set
// - results unsigned; justification 0 left, 1 right
// - justification and resolution writable only when disabled or special
// - resolution codes 000 8-bit, 010 10-bit, 100 12-bit, rest reserved
// - reserved resolution at conversion start sets command error and halts
// - special access lifts the normal write restrictions
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "acf_consts.vh"
module acf_regs #(
  parameter PRS_WIDTH = 7
) (
  input  wire       clk_sys,
  input  wire       rst,
  input  wire       clk_en,
  input  wire       soft_reset,
  input  wire       converter_enable,
  input  wire       special_access,
  input  wire       command_list_buffer_mode,
  input  wire       result_list_buffer_mode,
  input  wire       load_ok,
  input  wire       restart_request,
  input  wire       conversion_busy,
  input  wire       conversion_start,
  input  wire       ecc_error_detect,
  input  wire       first_result_stored,
  input  wire       initial_list_stored,
  input  wire       list_abort,
  input  wire [7:0] reg_addr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_write,
  input  wire       reg_read,
  output reg  [7:0] reg_rdata,
  output reg        irq,
  output reg        command_list_select,
  output reg        result_list_select,
  output reg        double_ecc_error_flag,
  output reg        command_error_flag,
  output reg        converter_ready,
  output reg        conversion_halt,
  output reg        conversion_clk_en,
  output reg        result_justification,
  output reg  [1:0] result_width_code,
  output reg  [2:0] resolution_select
);

  // ---------------------------------------------------------------
  // decoding helpers
  // ---------------------------------------------------------------
  function res_reserved;
    input [2:0] code;
    begin
      res_reserved = !(code == `ACF_RES_8BIT || code == `ACF_RES_10BIT ||
                       code == `ACF_RES_12BIT);
    end
  endfunction

  function [1:0] res_width;
    input [2:0] code;
    begin
      case (code)
        `ACF_RES_10BIT: res_width = 2'h1;
        `ACF_RES_12BIT: res_width = 2'h2;
        default:        res_width = 2'h0;
      endcase
    end
  endfunction

  // ---------------------------------------------------------------
  // write qualification
  // ---------------------------------------------------------------
  reg  [PRS_WIDTH-1:0] prescaler_value;
  reg  [PRS_WIDTH-1:0] div_count;
  reg  [2:0]           irq_status;
  reg  [2:0]           irq_enable;
  reg                  ready_prev;
  wire                 unlocked;
  wire                 wr_status;
  wire                 wr_clkdiv;
  wire                 wr_format;
  wire                 wr_irq_en;
  wire                 wr_irq_clr;
  wire                 wr_control;
  wire                 idle;
  wire                 ecc_set;
  wire                 cmd_err_set;
  wire                 ready_rise;
  wire [2:0]           irq_events;
  wire [2:0]           next_irq_status;
  wire                 cmd_toggle;
  wire                 res_toggle;

  // special access lifts the enable-time write lock on status, divider and format
  assign unlocked   = !converter_enable || special_access;
  assign wr_status  = reg_write && reg_addr == `ACF_OFS_STATUS;
  assign wr_clkdiv  = reg_write && reg_addr == `ACF_OFS_CLKDIV;
  assign wr_format  = reg_write && reg_addr == `ACF_OFS_FORMAT;
  assign wr_irq_en  = reg_write && reg_addr == `ACF_OFS_IRQ_ENABLE;
  assign wr_irq_clr = reg_write && reg_addr == `ACF_OFS_IRQ_CLEAR;
  assign wr_control = reg_write && reg_addr == `ACF_OFS_CONTROL;

  assign idle        = !conversion_busy && !conversion_halt;
  assign ecc_set     = ecc_error_detect && converter_enable;
  assign cmd_err_set = conversion_start && converter_enable &&
                       res_reserved(resolution_select);
  assign ready_rise  = idle && converter_enable && !ready_prev;
  assign irq_events  = {ready_rise, cmd_err_set, ecc_set};
  // set wins over clear
  assign next_irq_status = (irq_status &
                            ~(wr_irq_clr ? reg_wdata[2:0] : 3'h0)) |
                           irq_events;

  assign cmd_toggle = command_list_buffer_mode && idle &&
                      load_ok && restart_request;
  assign res_toggle = result_list_buffer_mode && initial_list_stored &&
                      !conversion_halt &&
                      (first_result_stored || list_abort);

  // ---------------------------------------------------------------
  // list select, error and ready state
  // ---------------------------------------------------------------
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      command_list_select   <= 1'b0;
      result_list_select    <= 1'b0;
      double_ecc_error_flag <= 1'b0;
      command_error_flag    <= 1'b0;
      conversion_halt       <= 1'b0;
      converter_ready       <= 1'b0;
      ready_prev            <= 1'b0;
    end else if (clk_en) begin
      ready_prev      <= idle && converter_enable;
      converter_ready <= idle && converter_enable;
      if (soft_reset) begin
        command_list_select   <= 1'b0;
        result_list_select    <= 1'b0;
        double_ecc_error_flag <= 1'b0;
        command_error_flag    <= 1'b0;
        conversion_halt       <= 1'b0;
      end else begin
        // only a soft reset lifts the halt, so a stuck error is visible
        if (ecc_set || cmd_err_set)
          conversion_halt <= 1'b1;
        if (!converter_enable)
          double_ecc_error_flag <= 1'b0;
        else if (ecc_set)
          double_ecc_error_flag <= 1'b1;
        if (cmd_err_set)
          command_error_flag <= 1'b1;
        else if (wr_control && reg_wdata[`ACF_CTL_CMD_ERR])
          command_error_flag <= 1'b0;
        // write bits 5 and 3 are dropped: flags are read only
        if (!command_list_buffer_mode)
          command_list_select <= 1'b0;
        else if (wr_status && unlocked)
          command_list_select <= reg_wdata[`ACF_STS_CMD_SEL];
        else if (cmd_toggle)
          command_list_select <= !command_list_select;
        if (!result_list_buffer_mode)
          result_list_select <= 1'b0;
        else if (wr_status && unlocked)
          result_list_select <= reg_wdata[`ACF_STS_RES_SEL];
        else if (res_toggle)
          result_list_select <= !result_list_select;
      end
    end
  end

  // ---------------------------------------------------------------
  // timing and format fields
  // ---------------------------------------------------------------
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      prescaler_value      <= `ACF_RST_PRESCALER;
      result_justification <= 1'b0;
      resolution_select    <= `ACF_RST_FORMAT_RES;
      result_width_code    <= 2'h0;
    end else if (clk_en) begin
      if (wr_clkdiv && unlocked)
        prescaler_value <= reg_wdata[PRS_WIDTH-1:0];
      if (wr_format && unlocked) begin
        result_justification <= reg_wdata[`ACF_FMT_JUST];
        resolution_select <= reg_wdata[`ACF_FMT_RES_HI:0];
      end
      result_width_code <= res_width(resolution_select);
    end
  end

  // ---------------------------------------------------------------
  // conversion clock: conversion_clk_en toggles once per half period
  // ---------------------------------------------------------------
  // toggling conversion_clk_en each P+1 cycles gives f_bus / (2 * (P+1))
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      div_count         <= {PRS_WIDTH{1'b0}};
      conversion_clk_en <= 1'b0;
    end else if (clk_en) begin
      if (!converter_enable || conversion_halt) begin
        div_count         <= {PRS_WIDTH{1'b0}};
        conversion_clk_en <= 1'b0;
      end else if (div_count >= prescaler_value) begin
        div_count         <= {PRS_WIDTH{1'b0}};
        conversion_clk_en <= !conversion_clk_en;
      end else begin
        div_count <= div_count + {{(PRS_WIDTH-1){1'b0}}, 1'b1};
      end
    end
  end

  // ---------------------------------------------------------------
  // interrupts
  // ---------------------------------------------------------------
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      irq_status <= 3'h0;
      irq_enable <= 3'h0;
      irq        <= 1'b0;
    end else if (clk_en) begin
      irq_status <= next_irq_status;
      if (wr_irq_en)
        irq_enable <= reg_wdata[2:0];
      irq <= |(next_irq_status & (wr_irq_en ? reg_wdata[2:0] : irq_enable));
    end
  end

  // ---------------------------------------------------------------
  // read port
  // ---------------------------------------------------------------
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (clk_en) begin
      if (reg_read) begin
        case (reg_addr)
          `ACF_OFS_STATUS:
            reg_rdata <= {command_list_select, result_list_select,
                          double_ecc_error_flag, 1'b0, converter_ready,
                          3'h0};
          `ACF_OFS_CLKDIV:
            reg_rdata <= {{(8-PRS_WIDTH){1'b0}}, prescaler_value};
          `ACF_OFS_FORMAT:
            reg_rdata <= {result_justification, 4'h0, resolution_select};
          `ACF_OFS_IRQ_STATUS: reg_rdata <= {5'h00, irq_status};
          `ACF_OFS_IRQ_ENABLE: reg_rdata <= {5'h00, irq_enable};
          `ACF_OFS_CONTROL:
            reg_rdata <= {conversion_halt, 6'h00, command_error_flag};
          default: reg_rdata <= 8'h00;
        endcase
      end else begin
        reg_rdata <= 8'h00;
      end
    end
  end

endmodule // acf_regs
`default_nettype wire

/* verification/acf_regs_props.sv */
`timescale 1ns/1ps
`default_nettype none
`include "acf_consts.vh"
module acf_regs_props (
  input wire logic       clk_sys,
  input wire logic       rst,
  input wire logic       clk_en,
  input wire logic       soft_reset,
  input wire logic       converter_enable,
  input wire logic       special_access,
  input wire logic       ecc_error_detect,
  input wire logic       command_list_buffer_mode,
  input wire logic       result_list_buffer_mode,
  input wire logic [7:0] reg_addr,
  input wire logic       reg_write,
  input wire logic       conversion_start,
  input wire logic       command_list_select,
  input wire logic       result_list_select,
  input wire logic       double_ecc_error_flag,
  input wire logic       command_error_flag,
  input wire logic       converter_ready,
  input wire logic       conversion_halt,
  input wire logic [2:0] resolution_select
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  wire fmt_lock = clk_en && reg_write && reg_addr == `ACF_OFS_FORMAT
                  && converter_enable && !special_access;
  wire bad_res = resolution_select[0] || resolution_select[2:1] == 2'h3;
  single_cmd_a: assert property (
    clk_en && !command_list_buffer_mode |=> !command_list_select)
    else $error("cmd select not zero");
  single_res_a: assert property (
    clk_en && !result_list_buffer_mode |=> !result_list_select)
    else $error("res select not zero");
  soft_clear_a: assert property (
    clk_en && soft_reset |=>
    !command_list_select && !result_list_select && !conversion_halt)
    else $error("soft reset incomplete");
  ecc_halt_a: assert property (
    clk_en && ecc_error_detect && converter_enable && !soft_reset |=>
    double_ecc_error_flag && conversion_halt)
    else $error("ecc not flagged");
  halt_hold_a: assert property (
    conversion_halt && !(clk_en && soft_reset) |=> conversion_halt)
    else $error("halt dropped");
  ecc_disable_a: assert property (
    clk_en && !converter_enable |=> !double_ecc_error_flag)
    else $error("ecc flag kept");
  fmt_lock_a: assert property (
    fmt_lock |=> $stable(resolution_select))
    else $error("locked format changed");
  bad_res_a: assert property (
    clk_en && conversion_start && converter_enable && bad_res &&
    !soft_reset |=> command_error_flag && conversion_halt)
    else $error("reserved code ran");
  halt_ready_a: assert property (
    clk_en && conversion_halt |=> !converter_ready)
    else $error("ready while halted");
  cover property (fmt_lock);
  cover property (clk_en && ecc_error_detect && converter_enable);
  cover property (clk_en && conversion_start && bad_res);
endmodule // acf_regs_props
bind acf_regs acf_regs_props acf_regs_props_i (
  .clk_sys(clk_sys), .rst(rst), .clk_en(clk_en), .soft_reset(soft_reset),
  .converter_enable(converter_enable), .special_access(special_access),
  .ecc_error_detect(ecc_error_detect),
  .command_list_buffer_mode(command_list_buffer_mode),
  .result_list_buffer_mode(result_list_buffer_mode),
  .reg_addr(reg_addr), .reg_write(reg_write),
  .conversion_start(conversion_start),
  .command_list_select(command_list_select),
  .result_list_select(result_list_select),
  .double_ecc_error_flag(double_ecc_error_flag),
  .command_error_flag(command_error_flag),
  .converter_ready(converter_ready), .conversion_halt(conversion_halt),
  .resolution_select(resolution_select)
);
`default_nettype wire

/* verification/acf_regs_bench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "acf_consts.vh"
module acf_regs_bench;
  localparam logic [7:0] a_sts = `ACF_OFS_STATUS, a_div = `ACF_OFS_CLKDIV;
  localparam logic [7:0] a_fmt = `ACF_OFS_FORMAT, a_ctl = `ACF_OFS_CONTROL;
  localparam logic [7:0] a_ien = `ACF_OFS_IRQ_ENABLE;
  localparam logic [7:0] a_icl = `ACF_OFS_IRQ_CLEAR;
  logic       clk_sys, rst, clk_en, soft_reset, converter_enable;
  logic       special_access, command_list_buffer_mode, load_ok;
  logic       result_list_buffer_mode, restart_request, conversion_busy;
  logic       conversion_start, ecc_error_detect, first_result_stored;
  logic       initial_list_stored, list_abort, reg_write, reg_read;
  logic [7:0] reg_addr, reg_wdata;
  wire logic [7:0] reg_rdata;
  wire logic       irq, command_list_select, result_list_select;
  wire logic       double_ecc_error_flag, command_error_flag, converter_ready;
  wire logic       conversion_halt, conversion_clk_en, result_justification;
  wire logic [1:0] result_width_code;
  wire logic [2:0] resolution_select;
  int   err_total = 0, total_checks = 0, cyc = 0, r0, r1;
  logic p;
  acf_regs acf_regs_i (
    .clk_sys(clk_sys), .rst(rst), .clk_en(clk_en), .soft_reset(soft_reset),
    .converter_enable(converter_enable), .special_access(special_access),
    .command_list_buffer_mode(command_list_buffer_mode),
    .result_list_buffer_mode(result_list_buffer_mode),
    .load_ok(load_ok), .restart_request(restart_request),
    .conversion_busy(conversion_busy), .conversion_start(conversion_start),
    .ecc_error_detect(ecc_error_detect),
    .first_result_stored(first_result_stored),
    .initial_list_stored(initial_list_stored), .list_abort(list_abort),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .irq(irq),
    .command_list_select(command_list_select),
    .result_list_select(result_list_select),
    .double_ecc_error_flag(double_ecc_error_flag),
    .command_error_flag(command_error_flag),
    .converter_ready(converter_ready), .conversion_halt(conversion_halt),
    .conversion_clk_en(conversion_clk_en),
    .result_justification(result_justification),
    .result_width_code(result_width_code),
    .resolution_select(resolution_select)
  );
  always #2 clk_sys = ~clk_sys;
  task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge clk_sys);
    reg_write <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_write <= 1'h0;
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] e, string nm);
    @(posedge clk_sys);
    reg_read <= 1'h1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_read <= 1'h0;
    @(negedge clk_sys);
    chk(nm, reg_rdata, e);
  endtask
  task automatic flow(logic b);
    @(posedge clk_sys);
    {conversion_busy, load_ok, restart_request} <= {b, 2'h3};
    @(posedge clk_sys);
    {conversion_busy, load_ok, restart_request} <= 3'h0;
    @(negedge clk_sys);
  endtask
  task automatic fire(int k);
    @(posedge clk_sys);
    {soft_reset, conversion_start, ecc_error_detect} <= 3'(k);
    @(posedge clk_sys);
    {soft_reset, conversion_start, ecc_error_detect} <= 3'h0;
    repeat (2) @(negedge clk_sys);
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // ---------------------------------------------
  // hang guard, tests need well under 2000 cycles
  // ---------------------------------------------
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      tally_and_finish();
    end
  end
  initial begin
    {clk_sys, soft_reset, converter_enable, special_access, load_ok} = '0;
    {restart_request, conversion_busy, conversion_start, list_abort} = '0;
    {ecc_error_detect, first_result_stored, initial_list_stored} = '0;
    {reg_write, reg_read, reg_addr, reg_wdata} = '0;
    {rst, clk_en, command_list_buffer_mode, result_list_buffer_mode} = 4'hF;
    repeat (12) @(posedge clk_sys);
    rst <= 1'h0;
    rd(a_sts, 8'h00, "status");
    rd(a_div, 8'h00, "divider");
    rd(8'h20, 8'h00, "unmapped");
    wr(a_sts, 8'hFF);
    rd(a_sts, 8'hC0, "status");
    wr(a_div, 8'h85);
    rd(a_div, 8'h05, "divider");
    for (int c = 0; c < 8; c++) begin
      wr(a_fmt, {5'h10, c[2:0]});
      repeat (2) @(negedge clk_sys);
      chk("width", {6'h00, result_width_code},
          (c == 2) ? 8'h01 : (c == 4) ? 8'h02 : 8'h00);
    end
    chk("justify", {7'h00, result_justification}, 8'h01);
    wr(a_fmt, 8'h84);
    $display("reset and format test done");
    @(posedge clk_sys) converter_enable <= 1'h1;
    wr(a_sts, 8'h00);
    wr(a_fmt, 8'h00);
    wr(a_div, 8'h00);
    rd(a_sts, 8'hC8, "status");
    rd(a_fmt, 8'h84, "format");
    rd(a_div, 8'h05, "divider");
    @(posedge clk_sys) special_access <= 1'h1;
    wr(a_fmt, 8'h02);
    rd(a_fmt, 8'h02, "format");
    @(posedge clk_sys) special_access <= 1'h0;
    // settle first, the divider output may move on this very edge
    @(negedge clk_sys);
    p = conversion_clk_en;
    {r0, r1} = '0;
    for (int i = 1; i < 40; i++) begin
      @(negedge clk_sys);
      if (conversion_clk_en && !p) {r0, r1} = {r1, i};
      p = conversion_clk_en;
    end
    chk("clock period", 8'(r1 - r0), 8'h0C);
    $display("lock and clock test done");
    flow(1'h1);
    chk("cmd select", {7'h00, command_list_select}, 8'h01);
    flow(1'h0);
    chk("cmd select", {7'h00, command_list_select}, 8'h00);
    @(posedge clk_sys) {initial_list_stored, first_result_stored} <= 2'h3;
    @(posedge clk_sys) {first_result_stored, list_abort} <= 2'h1;
    @(negedge clk_sys);
    chk("res select", {7'h00, result_list_select}, 8'h00);
    @(posedge clk_sys) list_abort <= 1'h0;
    @(negedge clk_sys);
    chk("res select", {7'h00, result_list_select}, 8'h01);
    @(posedge clk_sys);
    command_list_buffer_mode <= 1'h0;
    result_list_buffer_mode  <= 1'h0;
    special_access <= 1'h1;
    wr(a_sts, 8'hFF);
    rd(a_sts, 8'h08, "status");
    @(posedge clk_sys);
    command_list_buffer_mode <= 1'h1;
    result_list_buffer_mode  <= 1'h1;
    $display("list select test done");
    wr(a_fmt, 8'h05);
    fire(2);
    rd(a_ctl, 8'h81, "control");
    rd(a_sts, 8'h00, "status");
    fire(4);
    rd(a_ctl, 8'h00, "control");
    wr(a_icl, 8'hFF);
    wr(a_ien, 8'h00);
    fire(1);
    rd(a_sts, 8'h20, "status");
    chk("irq masked", {7'h00, irq}, 8'h00);
    wr(a_ien, 8'h01);
    repeat (2) @(negedge clk_sys);
    chk("irq", {7'h00, irq}, 8'h01);
    wr(a_icl, 8'h01);
    repeat (2) @(negedge clk_sys);
    chk("irq cleared", {7'h00, irq}, 8'h00);
    @(posedge clk_sys) converter_enable <= 1'h0;
    rd(a_sts, 8'h00, "status");
    rd(a_ctl, 8'h80, "control");
    fire(4);
    rd(a_ctl, 8'h00, "control");
    // write is legal here, so only the frozen enable can keep it out
    @(posedge clk_sys) clk_en <= 1'h0;
    wr(a_div, 8'h11);
    @(posedge clk_sys) clk_en <= 1'h1;
    rd(a_div, 8'h05, "frozen divider");
    $display("error and irq test done");
    tally_and_finish();
  end
endmodule // acf_regs_bench
`default_nettype wire
